// ==== inc/sdl_consts.svh ====
// Constants for the serial converter word loader: frame sizes, field positions,
// switch widths and link timing. Assumes a 250 MHz system clock on both ends.
//
// Function
// - Frame begins only on frame select falling
// - Wide: falling shift edges fill 24-bit register
// - Wide: 24th falling edge captures and executes
// - Host holds select high 12 ns between frames
// - Host may idle select low, pulse high
// - Narrow: 16th falling edge captures and executes
// - Wide: bits 17:16 mode, 15:0 code
// - Narrow: bits 15:14 mode, 13:0 code
// - Wide modes: normal, tristate, 100k, 1k
// - Narrow has three modes only
// - Narrow select 11 is reset, not mode
// - Host keeps select low for whole frame
// - Early select rise discards frame, nothing changes
// - Power-up preset zero or midscale until write
// - All-ones frame is software reset
// - Software reset cannot be aborted once started
// - Code is straight binary, full scale all ones
// - Top 4 bits to 15 segments, 12 ladder
// - Power-down frame also loads its code field
// - Frames travel most significant bit first
`ifndef SDL_CONSTS_SVH
`define SDL_CONSTS_SVH

`define SDL_WIDE_FRAME_W 24
`define SDL_NARROW_FRAME_W 16
`define SDL_WIDE_CODE_W 16
`define SDL_NARROW_CODE_W 14
`define SDL_CODE_BUS_W 16
`define SDL_SEG_W 15
`define SDL_LADDER_W 12
`define SDL_SEG_MSB_W 4
`define SDL_PD_W 2
`define SDL_CLK_PERIOD_NS 4
`define SDL_SYNC_HIGH_NS 12
`define SDL_SYNC_HIGH_CYC ((`SDL_SYNC_HIGH_NS + `SDL_CLK_PERIOD_NS - 1) / `SDL_CLK_PERIOD_NS)
`define SDL_HALF_CYC_DEF 16

`endif

// ==== inc/sdl_pkg.sv ====
// Types shared by both ends of the serial converter word loader.
// Assumes nothing beyond a SystemVerilog compiler.
`default_nettype none
package sdl_pkg;
    // Output stage mode held by the device
    typedef enum logic [1:0] {
        SDL_MODE_NORMAL = 2'h0,
        SDL_MODE_TRISTATE = 2'h1,
        SDL_MODE_PD_100K = 2'h2,
        SDL_MODE_PD_1K = 2'h3
    } sdl_mode_t;

    // Device receive states, Gray along idle-shift-done
    typedef enum logic [1:0] {
        SDL_DEV_IDLE = 2'h0,
        SDL_DEV_SHIFT = 2'h1,
        SDL_DEV_DONE = 2'h3
    } sdl_dev_state_t;

    // Host transmit states, Gray along idle-pre-lead-high-low-gap
    typedef enum logic [2:0] {
        SDL_HST_IDLE = 3'h0,
        SDL_HST_PRE = 3'h1,
        SDL_HST_LEAD = 3'h3,
        SDL_HST_HIGH = 3'h2,
        SDL_HST_LOW = 3'h6,
        SDL_HST_GAP = 3'h7
    } sdl_hst_state_t;
endpackage
`default_nettype wire

// ==== inc/sdl_if.sv ====
// Three-wire serial link between host and converter device.
// Assumes the host drives every wire; the device only listens.
`default_nettype none
interface sdl_if;
    logic sync_n; // Frame select, active low
    logic sclk; // Shift clock, sampled on falling edges
    logic din; // Serial data, MSB first

    // Converter end
    modport dev (
        input sync_n,
        input sclk,
        input din
    );

    // Controller end
    modport host (
        output sync_n,
        output sclk,
        output din
    );
endinterface
`default_nettype wire

// ==== rtl/sdl_segdec.sv ====
// Registered decode of the converter code into segment and ladder switch controls.
// Assumes a code already left-aligned to 16 bits by the caller.
`default_nettype none
`include "sdl_consts.svh"
module sdl_segdec #(
    parameter logic [`SDL_CODE_BUS_W-1:0] RESET_CODE = 16'h0000
) (
    input wire logic clk, // System clock
    input wire logic rst, // Asynchronous reset, active high
    input wire logic [`SDL_CODE_BUS_W-1:0] code, // Left-aligned converter code
    output logic [`SDL_SEG_W-1:0] seg, // Thermometer segment controls
    output logic [`SDL_LADDER_W-1:0] ladder // Ladder switch controls
);
    // Thermometer: segment i closes when the top nibble exceeds i
    function automatic logic [`SDL_SEG_W-1:0] thermo(input logic [`SDL_SEG_MSB_W-1:0] msb);
        logic [`SDL_SEG_W-1:0] t;
        t = '0;
        for (int i = 0; i < `SDL_SEG_W; i++) begin
            t[i] = (32'(msb) > i);
        end
        return t;
    endfunction

    localparam logic [`SDL_SEG_W-1:0] SEG_RST =
        thermo(RESET_CODE[`SDL_CODE_BUS_W-1 -: `SDL_SEG_MSB_W]);
    localparam logic [`SDL_LADDER_W-1:0] LAD_RST = RESET_CODE[`SDL_LADDER_W-1:0];

    wire logic [`SDL_SEG_W-1:0] next_seg = thermo(code[`SDL_CODE_BUS_W-1 -: `SDL_SEG_MSB_W]);

    // Register the decode so switch controls never glitch
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            seg <= SEG_RST;
            ladder <= LAD_RST;
        end else begin
            seg <= next_seg;
            ladder <= code[`SDL_LADDER_W-1:0];
        end
    end
endmodule
`default_nettype wire

// ==== rtl/sdl_device.sv ====
// Converter end of the serial word loader: receives frames, holds the code and mode.
// Assumes the link pins are asynchronous to clk and a shift clock slower than clk / 6.
`default_nettype none
`include "sdl_consts.svh"
module sdl_device #(
    parameter bit WIDE = 1'b1, // 1: 24-bit frame, 16-bit code; 0: 16-bit frame, 14-bit code
    parameter bit MIDSCALE = 1'b0 // Power-up preset: 1 midscale, 0 zero scale
) (
    input wire logic clk, // System clock, 250 MHz
    input wire logic rst, // Asynchronous reset, active high
    sdl_if.dev link, // Serial link from the host
    output logic [`SDL_CODE_BUS_W-1:0] dac_code, // Converter register, right aligned
    output sdl_pkg::sdl_mode_t pwrdn_mode, // Output stage mode
    output logic [`SDL_SEG_W-1:0] seg_ctrl, // Segment switch controls
    output logic [`SDL_LADDER_W-1:0] ladder_ctrl, // Ladder switch controls
    output logic update_pulse, // One cycle: frame executed as update
    output logic swreset_pulse, // One cycle: software reset executed
    output logic abort_pulse, // One cycle: frame discarded by early select rise
    output logic busy // Frame in progress
);
    localparam int FRAME_W = WIDE ? `SDL_WIDE_FRAME_W : `SDL_NARROW_FRAME_W;
    localparam int CODE_W = WIDE ? `SDL_WIDE_CODE_W : `SDL_NARROW_CODE_W;
    localparam int CNT_W = $clog2(FRAME_W);
    localparam logic [CNT_W-1:0] LAST_BIT = CNT_W'(FRAME_W - 1);
    // Preset codes, straight binary
    localparam logic [`SDL_CODE_BUS_W-1:0] MID_CODE = `SDL_CODE_BUS_W'(1) << (CODE_W - 1);
    localparam logic [`SDL_CODE_BUS_W-1:0] PRESET = MIDSCALE ? MID_CODE : '0;
    // Left-aligned preset for the decoder
    localparam logic [`SDL_CODE_BUS_W-1:0] PRESET_AL = PRESET << (`SDL_CODE_BUS_W - CODE_W);

    // Synchronisers: stage 1 only feeds stage 2
    logic sync_s1, sync_s2, sync_s3; // Frame select chain plus edge history
    logic sclk_s1, sclk_s2, sclk_s3; // Shift clock chain plus edge history
    logic din_s1, din_s2; // Data chain, aligned with stage 2 of the clocks

    // Receive state
    sdl_pkg::sdl_dev_state_t state; // Receive state
    sdl_pkg::sdl_dev_state_t next_state; // Next receive state
    logic [FRAME_W-1:0] shreg; // Input shift register
    logic [CNT_W-1:0] bit_cnt; // Falling edges taken in this frame

    // Two flops on every pin before any logic reads it
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sync_s1 <= 1'b1;
            sync_s2 <= 1'b1;
            sync_s3 <= 1'b1;
            sclk_s1 <= 1'b1;
            sclk_s2 <= 1'b1;
            sclk_s3 <= 1'b1;
            din_s1 <= 1'b0;
            din_s2 <= 1'b0;
        end else begin
            sync_s1 <= link.sync_n;
            sync_s2 <= sync_s1;
            sync_s3 <= sync_s2;
            sclk_s1 <= link.sclk;
            sclk_s2 <= sclk_s1;
            sclk_s3 <= sclk_s2;
            din_s1 <= link.din;
            din_s2 <= din_s1;
        end
    end

    // Edge detection on the settled copies only
    wire logic sync_fall = sync_s3 & ~sync_s2; // Start of a frame
    wire logic sync_high = sync_s2; // Select released
    wire logic sclk_fall = sclk_s3 & ~sclk_s2; // Sampling edge

    // Word as it stands after the current edge, MSB shifted in first
    wire logic [FRAME_W-1:0] word_next = {shreg[FRAME_W-2:0], din_s2};
    wire logic last_edge = sclk_fall && (bit_cnt == LAST_BIT);

    // Field split: mode bits sit just above the code
    wire logic [`SDL_PD_W-1:0] frame_pd = word_next[CODE_W +: `SDL_PD_W];
    wire logic [CODE_W-1:0] frame_code = word_next[CODE_W-1:0];
    wire logic pwrdn_select_hi = frame_pd[1]; // Upper select bit
    wire logic pwrdn_select_lo = frame_pd[0]; // Lower select bit
    // Top bits of a wide frame count only toward the reset pattern
    wire logic all_ones = &word_next;
    // Narrow part: select 11 belongs to the reset pattern, never a mode
    wire logic narrow_rsvd = !WIDE && pwrdn_select_hi && pwrdn_select_lo;

    // What the final edge does
    wire logic exec = (state == sdl_pkg::SDL_DEV_SHIFT) && !sync_high && last_edge;
    wire logic do_swreset = exec && all_ones;
    wire logic do_update = exec && !all_ones && !narrow_rsvd;
    // Abort only before the final edge; reset command runs to completion
    wire logic do_abort = (state == sdl_pkg::SDL_DEV_SHIFT) && sync_high;

    // Next state of the receiver
    always_comb begin
        next_state = state;
        case (state)
            sdl_pkg::SDL_DEV_IDLE: begin
                // Only a fresh falling select starts a frame
                if (sync_fall) begin
                    next_state = sdl_pkg::SDL_DEV_SHIFT;
                end
            end
            sdl_pkg::SDL_DEV_SHIFT: begin
                if (sync_high) begin
                    next_state = sdl_pkg::SDL_DEV_IDLE;
                end else if (last_edge) begin
                    next_state = sdl_pkg::SDL_DEV_DONE;
                end
            end
            sdl_pkg::SDL_DEV_DONE: begin
                // Further edges are ignored until select goes high
                if (sync_high) begin
                    next_state = sdl_pkg::SDL_DEV_IDLE;
                end
            end
            default: begin
                next_state = sdl_pkg::SDL_DEV_IDLE;
            end
        endcase
    end

    // State register
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state <= sdl_pkg::SDL_DEV_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // Shift register and edge count; cleared at start and on abort
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            shreg <= '0;
            bit_cnt <= '0;
        end else if (state != sdl_pkg::SDL_DEV_SHIFT || sync_high) begin
            shreg <= '0;
            bit_cnt <= '0;
        end else if (sclk_fall) begin
            shreg <= word_next;
            bit_cnt <= bit_cnt + CNT_W'(1);
        end
    end

    // Converter register and mode; a power-down frame still loads its code
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            dac_code <= PRESET;
            pwrdn_mode <= sdl_pkg::SDL_MODE_NORMAL;
        end else if (do_swreset) begin
            // Software reset returns to the power-up state
            dac_code <= PRESET;
            pwrdn_mode <= sdl_pkg::SDL_MODE_NORMAL;
        end else if (do_update) begin
            dac_code <= `SDL_CODE_BUS_W'(frame_code);
            pwrdn_mode <= sdl_pkg::sdl_mode_t'(frame_pd);
        end
    end

    // Event strobes and busy flag
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            update_pulse <= 1'b0;
            swreset_pulse <= 1'b0;
            abort_pulse <= 1'b0;
            busy <= 1'b0;
        end else begin
            update_pulse <= do_update;
            swreset_pulse <= do_swreset;
            abort_pulse <= do_abort;
            busy <= (next_state == sdl_pkg::SDL_DEV_SHIFT);
        end
    end

    // Decoder sees the code left-aligned so its top nibble drives the segments
    wire logic [`SDL_CODE_BUS_W-1:0] code_al = dac_code << (`SDL_CODE_BUS_W - CODE_W);

    sdl_segdec #(
        .RESET_CODE(PRESET_AL)
    ) u_segdec (
        .clk(clk),
        .rst(rst),
        .code(code_al),
        .seg(seg_ctrl),
        .ladder(ladder_ctrl)
    );
endmodule
`default_nettype wire

// ==== rtl/sdl_host.sv ====
// Controller end of the serial word loader: sends one frame per start request.
// Assumes the device samples on falling shift edges; shift clock made by division.
`default_nettype none
`include "sdl_consts.svh"
module sdl_host #(
    parameter bit WIDE = 1'b1, // 1: 24-bit frame; 0: 16-bit frame
    parameter int HALF = `SDL_HALF_CYC_DEF, // clk cycles per shift clock half period
    parameter bit IDLE_LOW = 1'b0 // Park select low between frames to save power
) (
    input wire logic clk, // System clock, 250 MHz
    input wire logic rst, // Asynchronous reset, active high
    sdl_if.host link, // Serial link to the device
    input wire logic start, // Pulse: send word
    input wire logic [(WIDE ? `SDL_WIDE_FRAME_W : `SDL_NARROW_FRAME_W)-1:0] word, // Frame, MSB sent first
    input wire logic abort_req, // Pulse: raise select early
    output logic busy, // Frame or gap in progress
    output logic done // Pulse: select raised after frame
);
    localparam int FRAME_W = WIDE ? `SDL_WIDE_FRAME_W : `SDL_NARROW_FRAME_W;
    localparam int CNT_W = $clog2(FRAME_W);
    localparam int GAP = (HALF > `SDL_SYNC_HIGH_CYC) ? HALF : `SDL_SYNC_HIGH_CYC;
    localparam int TMR_W = $clog2(GAP + 1);
    localparam logic [TMR_W-1:0] HALF_END = TMR_W'(HALF - 1);
    localparam logic [TMR_W-1:0] GAP_END = TMR_W'(GAP - 1);
    localparam logic [CNT_W-1:0] LAST_BIT = CNT_W'(FRAME_W - 1);

    sdl_pkg::sdl_hst_state_t state; // Transmit state
    logic [FRAME_W-1:0] shreg; // Outgoing bits, MSB at top
    logic [CNT_W-1:0] bit_cnt; // Bits already clocked out
    logic [TMR_W-1:0] tmr; // Cycle timer within a phase
    logic sync_n, sclk, din; // Registered pin drivers

    assign link.sync_n = sync_n;
    assign link.sclk = sclk;
    assign link.din = din;
    assign busy = (state != sdl_pkg::SDL_HST_IDLE);

    wire logic half_up = (tmr == HALF_END); // End of a half period
    wire logic gap_up = (tmr == GAP_END); // End of the select-high gap
    wire logic in_frame = (state == sdl_pkg::SDL_HST_LEAD) || (state == sdl_pkg::SDL_HST_HIGH)
        || (state == sdl_pkg::SDL_HST_LOW);

    // Sequencer: each phase lasts a fixed count, sclk idles high
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state <= sdl_pkg::SDL_HST_IDLE;
            shreg <= '0;
            bit_cnt <= '0;
            tmr <= '0;
            sync_n <= 1'b1;
            sclk <= 1'b1;
            din <= 1'b0;
            done <= 1'b0;
        end else begin
            done <= 1'b0;
            tmr <= tmr + TMR_W'(1);
            if (in_frame && abort_req) begin
                // Early rise makes the device drop the frame
                state <= sdl_pkg::SDL_HST_GAP;
                sync_n <= 1'b1;
                sclk <= 1'b1;
                tmr <= '0;
            end else begin
                case (state)
                    sdl_pkg::SDL_HST_IDLE: begin
                        tmr <= '0;
                        if (start) begin
                            shreg <= word;
                            bit_cnt <= '0;
                            // Parked low: a high pulse first gives a fresh fall
                            if (IDLE_LOW) begin
                                state <= sdl_pkg::SDL_HST_PRE;
                                sync_n <= 1'b1;
                            end else begin
                                state <= sdl_pkg::SDL_HST_LEAD;
                                sync_n <= 1'b0;
                            end
                        end
                    end
                    sdl_pkg::SDL_HST_PRE: begin
                        if (gap_up) begin
                            state <= sdl_pkg::SDL_HST_LEAD;
                            sync_n <= 1'b0;
                            tmr <= '0;
                        end
                    end
                    sdl_pkg::SDL_HST_LEAD: begin
                        if (half_up) begin
                            state <= sdl_pkg::SDL_HST_HIGH;
                            din <= shreg[FRAME_W-1];
                            tmr <= '0;
                        end
                    end
                    sdl_pkg::SDL_HST_HIGH: begin
                        if (half_up) begin
                            state <= sdl_pkg::SDL_HST_LOW;
                            sclk <= 1'b0;
                            tmr <= '0;
                        end
                    end
                    sdl_pkg::SDL_HST_LOW: begin
                        if (half_up) begin
                            tmr <= '0;
                            sclk <= 1'b1;
                            // Select stays low through every falling edge of the frame
                            if (bit_cnt == LAST_BIT) begin
                                state <= sdl_pkg::SDL_HST_GAP;
                                sync_n <= 1'b1;
                                done <= 1'b1;
                            end else begin
                                state <= sdl_pkg::SDL_HST_HIGH;
                                shreg <= {shreg[FRAME_W-2:0], 1'b0};
                                din <= shreg[FRAME_W-2];
                                bit_cnt <= bit_cnt + CNT_W'(1);
                            end
                        end
                    end
                    sdl_pkg::SDL_HST_GAP: begin
                        if (gap_up) begin
                            state <= sdl_pkg::SDL_HST_IDLE;
                            sync_n <= !IDLE_LOW;
                        end
                    end
                    default: begin
                        state <= sdl_pkg::SDL_HST_IDLE;
                    end
                endcase
            end
        end
    end
endmodule
`default_nettype wire

// ==== sim/sdl_link_assertions.sv ====
// Checker for the wide link: host wire rules and device answers.
// Assumes the wide host and device share clk, rst and one link.
`default_nettype none
module sdl_link_assertions #(
    parameter int FRAME_W = 24 // Falling edges per frame
) (
    input wire logic clk, // System clock
    input wire logic rst, // Async reset, active high
    input wire logic sync_n, // Frame select
    input wire logic sclk, // Shift clock
    input wire logic din, // Serial data
    input wire logic [15:0] dac_code, // Converter register
    input wire sdl_pkg::sdl_mode_t pwrdn_mode, // Output mode
    input wire logic [14:0] seg_ctrl, // Segment controls
    input wire logic [11:0] ladder_ctrl, // Ladder controls
    input wire logic update_pulse, // Update done
    input wire logic swreset_pulse, // Reset done
    input wire logic abort_pulse, // Frame discarded
    input wire logic busy // Device shifting
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    logic sclk_q; // Shift clock one cycle back
    logic [5:0] fall_cnt; // Falling edges inside this frame
    wire exec = update_pulse | swreset_pulse; // Any executed frame
    // Count falling shift edges; select high clears, as the device must
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sclk_q <= 1'b1;
            fall_cnt <= 6'h0;
        end else begin
            sclk_q <= sclk;
            fall_cnt <= sync_n ? 6'h0 : fall_cnt + 6'(sclk_q & ~sclk);
        end
    end
    // Final falling edge of a frame, seen as the wire changes
    sequence last_fall;
        $fell(sclk) && !sync_n && fall_cnt == 6'(FRAME_W - 1);
    endsequence
    sequence early_rise;
        $rose(sync_n) && fall_cnt != 6'h0 && fall_cnt < 6'(FRAME_W);
    endsequence
    AST_SCLK_IDLE: assert property (sync_n |-> sclk)
        else $error("shift clock low outside a frame");
    AST_DIN_STABLE: assert property ($fell(sclk) |-> $stable(din))
        else $error("data moved on a falling shift edge");
    AST_EXEC_COUNT: assert property (exec |-> fall_cnt == 6'(FRAME_W))
        else $error("frame executed at wrong edge count");
    AST_EXEC_SOON: assert property (last_fall |-> ##[1:6] exec)
        else $error("final edge did not execute");
    AST_ABORT: assert property (early_rise |-> ##[1:6] abort_pulse)
        else $error("early select rise not discarded");
    AST_NO_ABORT: assert property ($rose(sync_n) && fall_cnt == 6'(FRAME_W) |-> ##1 !abort_pulse [*6])
        else $error("completed frame flagged as aborted");
    AST_HOLD: assert property (!$stable(dac_code) || !$stable(pwrdn_mode) |-> exec)
        else $error("code or mode changed without a frame");
    AST_DECODE: assert property (exec |=> ladder_ctrl == dac_code[11:0]
        && seg_ctrl == 15'((16'h1 << dac_code[15:12]) - 16'h1))
        else $error("segment or ladder decode wrong");
    AST_SWRESET: assert property (swreset_pulse |-> dac_code == 16'h0
        && pwrdn_mode == sdl_pkg::SDL_MODE_NORMAL)
        else $error("software reset left code or mode");
    AST_BUSY: assert property ($fell(sync_n) |-> ##[1:5] busy)
        else $error("select fall did not start a frame");
endmodule
`default_nettype wire

// ==== sim/serial_dac_word_loader_tb.sv ====
// Bench: a wide and a narrow host-device pair, table rows then aborts.
// Assumes design files and inc/ compiled first; no partner model.
`default_nettype none
module serial_dac_word_loader_tb;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct {bit nar; logic [23:0] w; logic [15:0] code; logic [1:0] mode; int kind;} sdl_row_t;
    logic clk = 1'b0, rst = 1'b1; // Clock and reset
    logic st_w = 1'b0, st_n = 1'b0, ab_w = 1'b0, ab_n = 1'b0; // Host requests
    logic [23:0] wd_w = 24'h0; // Wide word
    logic [15:0] wd_n = 16'h0; // Narrow word
    logic hb_w, hb_n, hd_w, hd_n; // Host busy, done
    logic [15:0] code_w, code_n; // Converter registers
    sdl_pkg::sdl_mode_t mode_w, mode_n; // Output modes
    logic [14:0] seg_w, seg_n; // Segments
    logic [11:0] lad_w, lad_n; // Ladders
    logic upd_w, upd_n, swr_w, swr_n, abt_w, abt_n, db_w, db_n; // Device flags
    int error_cnt = 0, checks_done = 0, cyc = 0;
    int n_upd[2] = '{0, 0}, n_swr[2] = '{0, 0}, n_abt[2] = '{0, 0}, n_dn[2] = '{0, 0}; // Pulse tallies
    // Kind 0 update, 1 software reset, 2 nothing happens
    sdl_row_t rows[11] = '{'{0, 24'h00ffff, 16'hffff, 2'h0, 0}, '{0, 24'h01abcd, 16'habcd, 2'h1, 0},
        '{0, 24'h021234, 16'h1234, 2'h2, 0}, '{0, 24'h038000, 16'h8000, 2'h3, 0},
        '{0, 24'hfc5a5a, 16'h5a5a, 2'h0, 0}, '{0, 24'hffffff, 16'h0000, 2'h0, 1},
        '{1, 24'h003fff, 16'h3fff, 2'h0, 0}, '{1, 24'h004123, 16'h0123, 2'h1, 0},
        '{1, 24'h008abc, 16'h0abc, 2'h2, 0}, '{1, 24'h00c555, 16'h0abc, 2'h2, 2},
        '{1, 24'h00ffff, 16'h0000, 2'h0, 1}};
    sdl_if lw();
    sdl_if ln();
    // Wide pair runs on the default width; only the shift rate is shortened
    sdl_host #(.HALF(4)) i_sdl_host (.clk(clk), .rst(rst), .link(lw), .start(st_w),
        .word(wd_w), .abort_req(ab_w), .busy(hb_w), .done(hd_w));
    sdl_device i_sdl_device (.clk(clk), .rst(rst), .link(lw), .dac_code(code_w),
        .pwrdn_mode(mode_w), .seg_ctrl(seg_w), .ladder_ctrl(lad_w), .update_pulse(upd_w),
        .swreset_pulse(swr_w), .abort_pulse(abt_w), .busy(db_w));
    sdl_host #(.WIDE(1'b0), .HALF(4)) i_sdl_host_n (.clk(clk), .rst(rst), .link(ln), .start(st_n),
        .word(wd_n), .abort_req(ab_n), .busy(hb_n), .done(hd_n));
    sdl_device #(.WIDE(1'b0)) i_sdl_device_n (.clk(clk), .rst(rst), .link(ln), .dac_code(code_n),
        .pwrdn_mode(mode_n), .seg_ctrl(seg_n), .ladder_ctrl(lad_n), .update_pulse(upd_n),
        .swreset_pulse(swr_n), .abort_pulse(abt_n), .busy(db_n));
    sdl_link_assertions i_sdl_link_assertions (.clk(clk), .rst(rst), .sync_n(lw.sync_n),
        .sclk(lw.sclk), .din(lw.din), .dac_code(code_w), .pwrdn_mode(mode_w), .seg_ctrl(seg_w),
        .ladder_ctrl(lad_w), .update_pulse(upd_w), .swreset_pulse(swr_w), .abort_pulse(abt_w), .busy(db_w));
    // Free-running 250 MHz clock
    initial begin
        forever #2 clk = ~clk;
    end
    // Tally pulses; a flag that is unknown counts nothing
    always @(posedge clk) begin
        n_upd[0] += int'(upd_w === 1'b1);
        n_upd[1] += int'(upd_n === 1'b1);
        n_swr[0] += int'(swr_w === 1'b1);
        n_swr[1] += int'(swr_n === 1'b1);
        n_abt[0] += int'(abt_w === 1'b1);
        n_abt[1] += int'(abt_n === 1'b1);
        n_dn[0] += int'(hd_w === 1'b1);
        n_dn[1] += int'(hd_n === 1'b1);
    end
    // Hang guard, well above the few thousand cycles the run needs
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            error_cnt++;
            give_verdict();
        end
    end
    task automatic give_verdict();
        $display("checks_done=%0d error_cnt=%0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        checks_done++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Expected segment pattern: n low bits set
    function automatic logic [14:0] thermo(input logic [3:0] n);
        return 15'((16'h1 << n) - 16'h1);
    endfunction
    // One frame; ab above zero raises select early after ab cycles
    task automatic send(input bit nar, input logic [23:0] w, input int ab);
        int t;
        t = 0;
        @(posedge clk);
        st_w <= !nar;
        st_n <= nar;
        wd_w <= w;
        wd_n <= w[15:0];
        @(posedge clk);
        st_w <= 1'b0;
        st_n <= 1'b0;
        if (ab > 0) begin
            repeat (ab - 1) @(posedge clk);
            ab_w <= !nar;
            ab_n <= nar;
            @(posedge clk);
            ab_w <= 1'b0;
            ab_n <= 1'b0;
        end
        #1;
        while ((nar ? hb_n : hb_w) !== 1'b0 && t < 400) begin
            @(posedge clk);
            #1;
            t++;
        end
        if (t >= 400)
            chk(24'h1, 24'h0);
        repeat (4) @(posedge clk);
        #1;
    endtask
    initial begin
        logic [15:0] left;
        int eu, es, ea, ed;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        #1;
        chk(24'(code_w), 24'h0);
        chk(24'(code_n), 24'h0);
        chk(24'(mode_w), 24'h0);
        chk(24'(seg_w), 24'h0);
        foreach (rows[i]) begin
            eu = n_upd[rows[i].nar] + int'(rows[i].kind == 0);
            es = n_swr[rows[i].nar] + int'(rows[i].kind == 1);
            ed = n_dn[rows[i].nar] + 1;
            left = rows[i].nar ? {rows[i].code[13:0], 2'b00} : rows[i].code;
            send(rows[i].nar, rows[i].w, 0);
            chk(24'(rows[i].nar ? code_n : code_w), 24'(rows[i].code));
            chk(24'(rows[i].nar ? mode_n : mode_w), 24'(rows[i].mode));
            chk(24'(rows[i].nar ? lad_n : lad_w), 24'(left[11:0]));
            chk(24'(rows[i].nar ? seg_n : seg_w), 24'(thermo(left[15:12])));
            chk(24'(n_upd[rows[i].nar]), 24'(eu));
            chk(24'(n_swr[rows[i].nar]), 24'(es));
            chk(24'(n_dn[rows[i].nar]), 24'(ed));
        end
        // Early select rise on both pairs, then a clean frame after it
        for (int p = 0; p < 2; p++) begin
            ea = n_abt[p] + 1;
            eu = n_upd[p];
            ed = n_dn[p];
            send(p[0], 24'h004321, 60);
            chk(24'(n_abt[p]), 24'(ea));
            chk(24'(n_upd[p]), 24'(eu));
            chk(24'(n_dn[p]), 24'(ed));
            chk(24'(p ? code_n : code_w), 24'h0);
            send(p[0], 24'h001357, 0);
            chk(24'(p ? code_n : code_w), 24'h1357);
        end
        // Reset in mid-run restores the preset, and the link still works after it
        @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        #1;
        chk(24'(code_w), 24'h0);
        chk(24'(code_n), 24'h0);
        chk(24'(seg_w), 24'h0);
        @(posedge clk);
        rst <= 1'b0;
        send(1'b0, 24'h02beef, 0);
        chk(24'(code_w), 24'h00beef);
        chk(24'(mode_w), 24'h2);
        give_verdict();
    end
endmodule
`default_nettype wire
